// ===== uoe_pkg.sv
// Shared constants and types for the USB OUT endpoint control pair
// Behaviour
// - ISO OUT token while ready set: overrun, interrupt
// - Stall bit set by CPU forces STALL answers
// - ISO endpoint accepts DATA0 or DATA1 unchecked
// - ISO bit one then zero resets toggle
// - Toggle reset only when endpoint link idle
// - Oversize packet sets forced stall, answers STALL
// - ISO CRC or stuffing error sets error flag
// - Flush drops one packet, older of two
// - No flush while a packet is arriving
// - Auto clear ready after max-size bytes read
// - Max size resets: 8, endpoint one 1
// - Dual buffering when max size at most half
// - Endpoint zero IN and OUT size shared
// - Count registers load after good reception
// - Count read low byte before high byte
// - Per endpoint FIFO port: write IN, read OUT
// - Ready set on good packet, cleared on unload
// - Index register selects visible endpoint set
package uoe_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_EP = 5;
   localparam int EPW = 3;
   localparam int PW = 4;
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] FIFO_BYTES = 8'h10;
   localparam logic [7:0] HALF_BYTES = 8'h08;
   localparam int CPU_AW = 4;
   localparam int BUF_W = 11;
   // ==========================================================
   // Reset values
   localparam logic [7:0] MAX_PACKET_SIZE_RST = 8'h08;
   localparam logic [7:0] MAX_PACKET_SIZE_RST_EP1 = 8'h01;
   // ==========================================================
   // Device register offsets on the CPU port
   localparam logic [3:0] A_INDEX = 4'h0;
   localparam logic [3:0] A_CSR = 4'h1;
   localparam logic [3:0] A_IN_MAX_PACKET_SIZE = 4'h2;
   localparam logic [3:0] A_OUT_MAX_PACKET_SIZE = 4'h3;
   localparam logic [3:0] A_CNT_LO = 4'h4;
   localparam logic [3:0] A_CNT_HI = 4'h5;
   localparam logic [3:0] A_FIFO0 = 4'h8;
   // ==========================================================
   // Control/status bit positions
   localparam int B_READY = 0;
   localparam int B_OVR = 1;
   localparam int B_STALL = 2;
   localparam int B_ISO = 3;
   localparam int B_FSTALL = 4;
   localparam int B_DERR = 5;
   localparam int B_FLUSH = 6;
   localparam int B_AUTO = 7;
   // ==========================================================
   // Host controller registers on AHB-Lite
   localparam logic [31:0] H_CTRL = 32'h0000_0000;
   localparam logic [31:0] H_TXDATA = 32'h0000_0004;
   localparam logic [31:0] H_STATUS = 32'h0000_0008;
   localparam int C_EP_LSB = 0;
   localparam int C_PID1 = 4;
   localparam int C_ERR = 5;
   localparam int C_GO = 8;
   localparam int C_CLR = 9;
   localparam int S_BUSY = 0;
   localparam int S_HS_LSB = 4;
   localparam int S_DONE = 8;
   // ==========================================================
   // Handshake answers
   typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} uoe_hs_e;
endpackage : uoe_pkg

// ===== uoe_link_if.sv
// Serial-bus link between host controller end and OUT endpoint end
`timescale 1ns/100ps
interface uoe_link_if;
   logic tok_valid;
   logic [uoe_pkg::EPW-1:0] tok_ep;
   logic dat_valid;
   logic dat_ready;
   logic [7:0] dat_byte;
   logic dat_last;
   logic dat_pid1;
   logic dat_err;
   logic hs_valid;
   uoe_pkg::uoe_hs_e hs_code;
   modport dev (
      input tok_valid, tok_ep, dat_valid, dat_byte, dat_last, dat_pid1,
      input dat_err,
      output dat_ready, hs_valid, hs_code
   );
   modport host (
      output tok_valid, tok_ep, dat_valid, dat_byte, dat_last, dat_pid1,
      output dat_err,
      input dat_ready, hs_valid, hs_code
   );
endinterface : uoe_link_if

// ===== uoe_skid_buf.sv
// Two-entry valid/ready buffer
`timescale 1ns/100ps
module uoe_skid_buf #(
   parameter int W = 8
) (
   input wire logic mclk, // System clock
   input wire logic rst, // Async reset
   input wire logic in_valid, // Source has a word
   output logic in_ready, // Room for a word
   input wire logic [W-1:0] in_data, // Incoming word
   output logic out_valid, // Word available
   input wire logic out_ready, // Sink takes word
   output logic [W-1:0] out_data // Oldest word
);
   logic [W-1:0] mem_reg [2];
   logic wp_reg;
   logic rp_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pull;
   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = mem_reg[rp_reg];
   assign push = in_valid & in_ready;
   assign pull = out_valid & out_ready;
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) begin
            wp_reg <= ~wp_reg;
         end
         if (pull) begin
            rp_reg <= ~rp_reg;
         end
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pull};
      end
   end
endmodule : uoe_skid_buf

// ===== uoe_device.sv
// OUT endpoint control, status, buffering and FIFO ports
//
// Implementation choices: the register offsets and the strobe-based CPU port to the registers.
`timescale 1ns/100ps
module uoe_device (
   input wire logic mclk, // System clock
   input wire logic rst, // Async reset
   uoe_link_if.dev lnk, // Link from host controller
   input wire logic [uoe_pkg::CPU_AW-1:0] cpu_addr, // Register address
   input wire logic cpu_wr, // Write strobe
   input wire logic cpu_rd, // Read strobe
   input wire logic [7:0] cpu_wdata, // Write data
   output logic [7:0] cpu_rdata, // Read data, next cycle
   output logic in_push, // Byte for an IN FIFO
   output logic [uoe_pkg::EPW-1:0] in_push_ep, // Its endpoint
   output logic [7:0] in_push_data, // Its data
   output logic shared_endpoint_irq_status_set // Overrun event
);
   import uoe_pkg::*;
   typedef enum {ST_IDLE, ST_RX} uoe_rx_e;
   // ==========================================================
   // State
   logic [7:0] mem_reg [NUM_EP][FIFO_DEPTH];
   logic [PW-1:0] wptr_reg [NUM_EP], rptr_reg [NUM_EP], hbase_reg [NUM_EP];
   logic [PW:0] len_reg [NUM_EP][2];
   logic [1:0] pcnt_reg [NUM_EP];
   logic [7:0] cnt_reg, popped_reg [NUM_EP], csr_reg [NUM_EP];
   logic [7:0] out_max_packet_size_reg [NUM_EP], in_max_packet_size_reg [NUM_EP];
   logic [NUM_EP-1:0] tog_reg, rel;
   logic [EPW-1:0] idx_reg, ep_reg;
   logic room_reg, hs_valid_reg;
   uoe_rx_e st_reg;
   uoe_hs_e hs_code_reg, hs_next;
   // ==========================================================
   // Decoding
   function automatic logic is_fifo(input logic [CPU_AW-1:0] a);
      return (a >= A_FIFO0) && (a < A_FIFO0 + 4'(NUM_EP));
   endfunction : is_fifo
   function automatic logic fifo_room(input logic [1:0] pc,
                                      input logic [7:0] mp);
      if (mp <= HALF_BYTES) begin
         return pc != 2'h2;
      end
      return pc == 2'h0;
   endfunction : fifo_room
   // ==========================================================
   // Link receive path through the two-entry buffer
   logic [BUF_W-1:0] b_data;
   logic b_valid, b_ready;
   uoe_skid_buf #(.W(BUF_W)) u_buf (
      .mclk(mclk),
      .rst(rst),
      .in_valid(lnk.dat_valid),
      .in_ready(lnk.dat_ready),
      .in_data({lnk.dat_last, lnk.dat_pid1, lnk.dat_err, lnk.dat_byte}),
      .out_valid(b_valid),
      .out_ready(b_ready),
      .out_data(b_data)
   );
   logic take, pkt_end, b_last, b_pid1, b_err, ep_iso, ep_halt, oversize;
   logic commit, tok_take, tok_ovr, csr_wr, pop;
   logic [7:0] total, ep_csr, ep_max_packet_size;
   logic [PW-1:0] wr_pos;
   logic [EPW-1:0] f_ep;
   assign b_ready = (st_reg == ST_RX);
   assign take = b_valid & b_ready;
   assign b_last = b_data[10];
   assign b_pid1 = b_data[9];
   assign b_err = b_data[8];
   assign pkt_end = take & b_last;
   assign total = cnt_reg + 8'h01;
   assign ep_csr = csr_reg[ep_reg];
   assign ep_max_packet_size = out_max_packet_size_reg[ep_reg];
   assign ep_iso = ep_csr[B_ISO];
   assign ep_halt = ep_csr[B_STALL] | ep_csr[B_FSTALL];
   assign oversize = total > ep_max_packet_size;
   assign wr_pos = wptr_reg[ep_reg] + cnt_reg[PW-1:0];
   // Wrong toggle on a non-ISO packet is a retry: acknowledged, dropped
   assign commit = pkt_end & ~ep_halt & ~b_err & ~oversize & room_reg &
                   (total <= FIFO_BYTES) &
                   (ep_iso | (b_pid1 == tog_reg[ep_reg]));
   assign tok_take = (st_reg == ST_IDLE) & lnk.tok_valid &
                     (lnk.tok_ep < 3'(NUM_EP));
   assign tok_ovr = tok_take & csr_reg[lnk.tok_ep][B_ISO] &
                    (pcnt_reg[lnk.tok_ep] != 2'h0);
   always_comb begin
      if (ep_halt || (oversize && !b_err)) begin
         hs_next = HS_STALL;
      end else if (b_err || ep_iso) begin
         hs_next = HS_NONE;
      end else if (!room_reg || total > FIFO_BYTES) begin
         hs_next = HS_NAK;
      end else begin
         hs_next = HS_ACK;
      end
   end
   // ==========================================================
   // CPU side decode
   assign f_ep = EPW'(cpu_addr - A_FIFO0);
   assign csr_wr = cpu_wr && (cpu_addr == A_CSR);
   assign pop = cpu_rd && is_fifo(cpu_addr) && (pcnt_reg[f_ep] != 2'h0);
   // Releasing the head packet: ready cleared, flush, or auto clear
   always_comb begin
      for (int e = 0; e < NUM_EP; e++) begin
         rel[e] = 1'b0;
         if (csr_wr && idx_reg == EPW'(e) && pcnt_reg[e] != 2'h0 &&
             (!cpu_wdata[B_READY] || cpu_wdata[B_FLUSH])) begin
            rel[e] = 1'b1;
         end
         if (pop && f_ep == EPW'(e) && csr_reg[e][B_AUTO] &&
             popped_reg[e] + 8'h01 == out_max_packet_size_reg[e]) begin
            rel[e] = 1'b1;
         end
      end
   end
   // ==========================================================
   // Packet bookkeeping per endpoint
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int e = 0; e < NUM_EP; e++) begin
            wptr_reg[e] <= '0;
            rptr_reg[e] <= '0;
            hbase_reg[e] <= '0;
            pcnt_reg[e] <= 2'h0;
            popped_reg[e] <= 8'h00;
            len_reg[e][0] <= '0;
            len_reg[e][1] <= '0;
         end
      end else begin
         for (int e = 0; e < NUM_EP; e++) begin
            if (pop && f_ep == EPW'(e)) begin
               rptr_reg[e] <= rptr_reg[e] + 4'h1;
               popped_reg[e] <= popped_reg[e] + 8'h01;
            end
            if (rel[e]) begin
               hbase_reg[e] <= hbase_reg[e] + len_reg[e][0][PW-1:0];
               rptr_reg[e] <= hbase_reg[e] + len_reg[e][0][PW-1:0];
               popped_reg[e] <= 8'h00;
               len_reg[e][0] <= len_reg[e][1];
            end
            if (commit && ep_reg == EPW'(e)) begin
               wptr_reg[e] <= wptr_reg[e] + total[PW-1:0];
               len_reg[e][pcnt_reg[e][0] & ~rel[e]] <= total[PW:0];
            end
            pcnt_reg[e] <= pcnt_reg[e] - {1'b0, rel[e]} +
                           {1'b0, commit && ep_reg == EPW'(e)};
         end
      end
   end
   // Data storage needs no reset
   always_ff @(posedge mclk) begin
      if (take && room_reg && cnt_reg < ep_max_packet_size && cnt_reg < FIFO_BYTES) begin
         mem_reg[ep_reg][wr_pos] <= b_data[7:0];
      end
   end
   // ==========================================================
   // Control/status, sizes, index and toggles
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idx_reg <= '0;
         tog_reg <= '0;
         for (int e = 0; e < NUM_EP; e++) begin
            csr_reg[e] <= 8'h00;
            out_max_packet_size_reg[e] <= (e == 1) ? MAX_PACKET_SIZE_RST_EP1 : MAX_PACKET_SIZE_RST;
            in_max_packet_size_reg[e] <= (e == 1) ? MAX_PACKET_SIZE_RST_EP1 : MAX_PACKET_SIZE_RST;
         end
      end else begin
         if (cpu_wr && cpu_addr == A_INDEX &&
             cpu_wdata[EPW-1:0] < 3'(NUM_EP)) begin
            idx_reg <= cpu_wdata[EPW-1:0];
         end
         for (int e = 0; e < NUM_EP; e++) begin
            if (csr_wr && idx_reg == EPW'(e)) begin
               csr_reg[e][B_STALL] <= cpu_wdata[B_STALL];
               csr_reg[e][B_ISO] <= cpu_wdata[B_ISO];
               csr_reg[e][B_AUTO] <= cpu_wdata[B_AUTO];
               // Writing one keeps a flag, zero clears it
               csr_reg[e][B_OVR] <= csr_reg[e][B_OVR] & cpu_wdata[B_OVR];
               csr_reg[e][B_FSTALL] <= csr_reg[e][B_FSTALL] &
                                       cpu_wdata[B_FSTALL];
               csr_reg[e][B_DERR] <= csr_reg[e][B_DERR] & cpu_wdata[B_DERR];
               // Assumes the endpoint sees no OUT traffic meanwhile
               if (csr_reg[e][B_ISO] && !cpu_wdata[B_ISO]) begin
                  tog_reg[e] <= 1'b0;
               end
            end
            // Endpoint zero keeps both sizes equal on any write
            if (cpu_wr && (cpu_addr == A_OUT_MAX_PACKET_SIZE || cpu_addr == A_IN_MAX_PACKET_SIZE) &&
                idx_reg == EPW'(e)) begin
               if (cpu_addr == A_OUT_MAX_PACKET_SIZE || e == 0) begin
                  out_max_packet_size_reg[e] <= cpu_wdata;
               end
               if (cpu_addr == A_IN_MAX_PACKET_SIZE || e == 0) begin
                  in_max_packet_size_reg[e] <= cpu_wdata;
               end
            end
            // Hardware sets come last so a set beats a same-cycle clear
            if (tok_ovr && lnk.tok_ep == EPW'(e)) begin
               csr_reg[e][B_OVR] <= 1'b1;
            end
            if (pkt_end && ep_reg == EPW'(e)) begin
               if (oversize && !b_err) begin
                  csr_reg[e][B_FSTALL] <= 1'b1;
               end
               if (ep_iso && b_err) begin
                  csr_reg[e][B_DERR] <= 1'b1;
               end
            end
            if (commit && ep_reg == EPW'(e) && !ep_iso) begin
               tog_reg[e] <= ~tog_reg[e];
            end
         end
      end
   end
   // ==========================================================
   // Receive sequencing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= ST_IDLE;
         ep_reg <= '0;
         cnt_reg <= 8'h00;
         room_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               if (tok_take) begin
                  st_reg <= ST_RX;
                  ep_reg <= lnk.tok_ep;
                  cnt_reg <= 8'h00;
                  room_reg <= fifo_room(pcnt_reg[lnk.tok_ep],
                                        out_max_packet_size_reg[lnk.tok_ep]);
               end
            end
            ST_RX: begin
               if (take) begin
                  // Saturate at 255; total then wraps to 0, so a runaway packet does not read oversize
                  cnt_reg <= (cnt_reg == 8'hff) ? cnt_reg : total;
                  if (b_last) begin
                     st_reg <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign lnk.hs_valid = hs_valid_reg;
   assign lnk.hs_code = hs_code_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hs_valid_reg <= 1'b0;
         hs_code_reg <= HS_NONE;
         shared_endpoint_irq_status_set <= 1'b0;
      end else begin
         hs_valid_reg <= pkt_end;
         if (pkt_end) begin
            hs_code_reg <= hs_next;
         end
         shared_endpoint_irq_status_set <= tok_ovr;
      end
   end
   // ==========================================================
   // CPU read data and IN FIFO writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cpu_rdata <= 8'h00;
         in_push <= 1'b0;
         in_push_ep <= '0;
         in_push_data <= 8'h00;
      end else begin
         in_push <= cpu_wr && is_fifo(cpu_addr);
         if (cpu_wr && is_fifo(cpu_addr)) begin
            in_push_ep <= f_ep;
            in_push_data <= cpu_wdata;
         end
         if (cpu_rd) begin
            case (cpu_addr)
               A_INDEX: cpu_rdata <= {5'h00, idx_reg};
               A_CSR: cpu_rdata <= {csr_reg[idx_reg][7], 1'b0,
                                    csr_reg[idx_reg][5:1],
                                    pcnt_reg[idx_reg] != 2'h0};
               A_IN_MAX_PACKET_SIZE: cpu_rdata <= in_max_packet_size_reg[idx_reg];
               A_OUT_MAX_PACKET_SIZE: cpu_rdata <= out_max_packet_size_reg[idx_reg];
               // Count fits the low byte; high byte always reads zero
               A_CNT_LO: cpu_rdata <= (pcnt_reg[idx_reg] != 2'h0) ?
                                      {3'h0, len_reg[idx_reg][0]} :
                                      8'h00;
               A_CNT_HI: cpu_rdata <= 8'h00;
               default: cpu_rdata <= pop ?
                                     mem_reg[f_ep][rptr_reg[f_ep]] : 8'h00;
            endcase
         end
      end
   end
endmodule : uoe_device

// ===== uoe_host.sv
// Host controller end: AHB-Lite orders, sends OUT packets on the link
`timescale 1ns/100ps
module uoe_host (
   input wire logic mclk, // System clock
   input wire logic rst, // Async reset
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Always ready
   output logic [31:0] hrdata, // Read data
   output logic hresp, // Always OKAY
   uoe_link_if.host lnk // Link to endpoint
);
   import uoe_pkg::*;
   typedef enum {HT_IDLE, HT_TOK, HT_DATA, HT_WAIT} uoe_host_e;
   logic [7:0] txb_reg [FIFO_DEPTH];
   logic [PW:0] txlen_reg;
   logic [PW:0] txi_reg;
   logic [EPW-1:0] ep_reg;
   logic pid1_reg;
   logic err_reg;
   logic done_reg;
   uoe_hs_e last_hs_reg;
   uoe_host_e st_reg;
   logic ap_wr_reg;
   logic [31:0] ap_addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] status_w;
   logic ap_take;
   logic busy;
   logic wr_ctrl;
   logic wr_tx;
   // ==========================================================
   // AHB-Lite slave, zero wait states
   assign ap_take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign busy = (st_reg != HT_IDLE);
   assign wr_ctrl = ap_wr_reg && (ap_addr_reg == H_CTRL);
   assign wr_tx = ap_wr_reg && (ap_addr_reg == H_TXDATA);
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[S_BUSY] = busy;
      status_w[S_HS_LSB +: 2] = last_hs_reg;
      status_w[S_DONE] = done_reg;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ap_wr_reg <= 1'b0;
         ap_addr_reg <= 32'h0000_0000;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         ap_wr_reg <= ap_take & hwrite;
         if (ap_take) begin
            ap_addr_reg <= haddr;
         end
         if (ap_take && !hwrite) begin
            hrdata_reg <= (haddr == H_STATUS) ? status_w : 32'h0000_0000;
         end
      end
   end
   // ==========================================================
   // Packet staging, only while idle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txlen_reg <= '0;
      end else if (!busy) begin
         if (wr_ctrl && hwdata[C_CLR]) begin
            txlen_reg <= '0;
         end else if (wr_tx && txlen_reg < 5'(FIFO_DEPTH)) begin
            txlen_reg <= txlen_reg + 5'h01;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!busy && wr_tx && txlen_reg < 5'(FIFO_DEPTH)) begin
         txb_reg[txlen_reg[PW-1:0]] <= hwdata[7:0];
      end
   end
   // ==========================================================
   // Link sequencing: token, bytes, wait for answer
   assign lnk.tok_valid = (st_reg == HT_TOK);
   assign lnk.tok_ep = ep_reg;
   assign lnk.dat_valid = (st_reg == HT_DATA);
   assign lnk.dat_byte = txb_reg[txi_reg[PW-1:0]];
   assign lnk.dat_last = (txi_reg + 5'h01 == txlen_reg);
   assign lnk.dat_pid1 = pid1_reg;
   assign lnk.dat_err = err_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= HT_IDLE;
         ep_reg <= '0;
         pid1_reg <= 1'b0;
         err_reg <= 1'b0;
         done_reg <= 1'b0;
         txi_reg <= '0;
         last_hs_reg <= HS_NONE;
      end else begin
         unique case (st_reg)
            HT_IDLE: begin
               if (wr_ctrl && hwdata[C_GO] && txlen_reg != '0) begin
                  st_reg <= HT_TOK;
                  ep_reg <= hwdata[C_EP_LSB +: EPW];
                  pid1_reg <= hwdata[C_PID1];
                  err_reg <= hwdata[C_ERR];
                  done_reg <= 1'b0;
                  txi_reg <= '0;
               end
            end
            HT_TOK: st_reg <= HT_DATA;
            HT_DATA: begin
               if (lnk.dat_ready) begin
                  txi_reg <= txi_reg + 5'h01;
                  if (lnk.dat_last) begin
                     st_reg <= HT_WAIT;
                  end
               end
            end
            HT_WAIT: begin
               if (lnk.hs_valid) begin
                  last_hs_reg <= lnk.hs_code;
                  done_reg <= 1'b1;
                  st_reg <= HT_IDLE;
               end
            end
         endcase
      end
   end
endmodule : uoe_host

// ===== uoe_properties.sv
// Link protocol checks for the OUT endpoint pair
`timescale 1ns/100ps
module uoe_properties (
   input wire logic mclk, // Clock
   input wire logic rst, // Reset
   input wire logic tok_valid, // Token
   input wire logic dat_valid, // Byte offered
   input wire logic dat_ready, // Room for byte
   input wire logic dat_last, // Final byte
   input wire logic hs_valid, // Answer pulse
   input wire uoe_pkg::uoe_hs_e hs_code // Answer code
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence last_take; dat_valid && dat_ready && dat_last; endsequence
   sequence answer; hs_valid ##1 !hs_valid; endsequence
   answer_due_a: assert property (last_take |-> ##[1:6] answer)
      else $error("no answer after last byte");
   code_holds_a: assert property (!hs_valid |-> $stable(hs_code))
      else $error("answer code moved");
   token_pulse_a: assert property (tok_valid |=> !tok_valid)
      else $error("token too long");
   token_first_a: assert property (tok_valid |=> dat_valid)
      else $error("no data after token");
   token_clean_a: assert property (tok_valid |-> !dat_valid)
      else $error("token inside packet");
   byte_held_a: assert property (dat_valid && !dat_ready |=> dat_valid)
      else $error("byte dropped while stalled");
   answer_clean_a: assert property (hs_valid |-> !dat_valid)
      else $error("data beside answer");
   answer_room_a: assert property (hs_valid |-> dat_ready)
      else $error("buffer full at answer");
endmodule : uoe_properties

// ===== usb_out_endpoint_control_test.sv
// Self-checking bench for the OUT endpoint pair
`timescale 1ns/100ps
module usb_out_endpoint_control_test;
   import uoe_pkg::*;
   logic mclk = 0, rst = 1, hsel = 1, hwrite = 0, wr = 0, rd = 0, hrdy;
   logic [1:0] htrans = 0;
   logic [3:0] ca = 0;
   logic [7:0] cw = 0, crd, r, hs, pdat;
   logic [2:0] pep;
   logic irq, push;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, st;
   int bad_count = 0, compares = 0, cyc = 0, irq_cnt = 0;
   uoe_link_if lnk ();
   uoe_device uoe_device_inst (.mclk, .rst, .lnk, .cpu_addr(ca),
      .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(cw), .cpu_rdata(crd),
      .in_push(push), .in_push_ep(pep), .in_push_data(pdat),
      .shared_endpoint_irq_status_set(irq));
   uoe_host uoe_host_inst (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hrdy), .hreadyout(hrdy), .hrdata,
      .hresp(), .lnk);
   uoe_properties chk_inst (.mclk, .rst, .tok_valid(lnk.tok_valid),
      .dat_valid(lnk.dat_valid), .dat_ready(lnk.dat_ready),
      .dat_last(lnk.dat_last), .hs_valid(lnk.hs_valid),
      .hs_code(lnk.hs_code));
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (irq === 1'b1) irq_cnt++;
      if (cyc == 20000) bad_count++;
      if (cyc == 20000) finish_test();
   end
   task automatic chk(input logic [7:0] s, e);
      compares++;
      if (s !== e) bad_count++;
      if (s !== e) $display("ERROR %0t: got %h want %h", $time, s, e);
   endtask : chk
   task automatic cpu(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      {ca, cw, wr, rd} <= {a, d, w, !w};
      @(posedge mclk);
      {wr, rd} <= 2'b00;
      // Read data lands on the taking edge, so look just after it
      #1 r = crd;
   endtask : cpu
   task automatic ahb(input logic w, input logic [31:0] a, d);
      @(posedge mclk);
      {haddr, hwrite, htrans} <= {a, w, 2'b10};
      do @(posedge mclk); while (hrdy !== 1'b1);
      {htrans, hwdata} <= {2'b00, d};
      do @(posedge mclk); while (hrdy !== 1'b1);
      st = hrdata;
   endtask : ahb
   task automatic send(input int ep, p, e, n);
      ahb(1, H_CTRL, 32'h200);
      for (int i = 0; i < n; i++) ahb(1, H_TXDATA, 32'h0a0 + 32'(i));
      ahb(1, H_CTRL, 32'h100 | 32'(ep + (p << C_PID1) + (e << C_ERR)));
      st = 0;
      while (st[S_DONE] !== 1'b1) ahb(0, H_STATUS, 0);
      hs = 8'(st[5:4]);
   endtask : send
   task automatic finish_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic t_sizes();
      for (int i = 0; i < NUM_EP; i++) begin
         cpu(1, A_INDEX, 8'(i));
         cpu(0, A_OUT_MAX_PACKET_SIZE, 8'h00);
         chk(r, (i == 1) ? MAX_PACKET_SIZE_RST_EP1 : MAX_PACKET_SIZE_RST);
      end
   endtask : t_sizes
   task automatic t_iso();
      cpu(1, A_CSR, 8'h08);
      send(4, 1, 1, 2);
      send(4, 1, 0, 2);
      send(4, 1, 0, 2);
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h2b);
      chk(8'(irq_cnt), 8'h01);
   endtask : t_iso
   task automatic t_ep1();
      send(1, 0, 0, 1);
      send(1, 1, 0, 1);
      chk(hs, 8'(HS_ACK));
      send(1, 0, 0, 1);
      chk(hs, 8'(HS_NAK));
      cpu(1, A_INDEX, 8'h01);
      cpu(0, A_FIFO0 + 4'h1, 8'h00);
      chk(r, 8'ha0);
      // Ready kept at one so the flush alone drops the head packet
      cpu(1, A_CSR, 8'h41);
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h01);
      cpu(1, A_CSR, 8'h41);
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h00);
   endtask : t_ep1
   task automatic t_ctrl();
      cpu(1, A_INDEX, 8'h00);
      cpu(1, A_IN_MAX_PACKET_SIZE, 8'h10);
      cpu(0, A_OUT_MAX_PACKET_SIZE, 8'h00);
      chk(r, 8'h10);
      cpu(1, A_INDEX, 8'h02);
      cpu(1, A_FIFO0 + 4'h2, 8'h5a);
      chk({push, 4'h0, pep}, 8'h82);
      chk(pdat, 8'h5a);
      cpu(1, A_CSR, 8'h04);
      send(2, 0, 0, 1);
      chk(hs, 8'(HS_STALL));
      cpu(1, A_CSR, 8'h00);
      cpu(1, A_OUT_MAX_PACKET_SIZE, 8'h03);
      send(2, 0, 0, 3);
      chk(hs, 8'(HS_ACK));
      cpu(0, A_CNT_LO, 8'h00);
      chk(r, 8'h03);
      cpu(0, A_CNT_HI, 8'h00);
      chk(r, 8'h00);
      cpu(1, A_CSR, 8'h81);
      for (int i = 0; i < 3; i++) begin
         cpu(0, A_FIFO0 + 4'h2, 8'h00);
         chk(r, 8'ha0 + 8'(i));
      end
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h80);
      send(2, 1, 0, 4);
      chk(hs, 8'(HS_STALL));
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h90);
      cpu(1, A_CSR, 8'h88);
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h88);
      // Toggle restart with the link idle
      cpu(1, A_CSR, 8'h80);
      send(2, 0, 0, 1);
      cpu(0, A_CSR, 8'h00);
      chk(r, 8'h81);
   endtask : t_ctrl
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      t_sizes();
      t_iso();
      t_ep1();
      t_ctrl();
      finish_test();
   end
endmodule : usb_out_endpoint_control_test
